// File: rtl/fte_consts.vh
/*
  Shared constants of the 100 Mb/s transmit coding path: code-groups,
  FIFO entry layout, scrambler and line-code settings.
  Assumes inclusion by its bare name from design, checker and bench files.
*/
`ifndef FTE_CONSTS_VH
`define FTE_CONSTS_VH

// ----------------------------------------------------------------
// Code-groups, sent MSB first
// ----------------------------------------------------------------
`define FTE_CG_IDLE 5'h1f
`define FTE_CG_J 5'h18
`define FTE_CG_K 5'h11
`define FTE_CG_T 5'h0d
`define FTE_CG_R 5'h07
`define FTE_CG_H 5'h04
`define FTE_NIB_PRE 4'h5

// ----------------------------------------------------------------
// FIFO entry {last, error, nibble}
// ----------------------------------------------------------------
`define FTE_FIFO_DEPTH 8
`define FTE_FIFO_AW 3
`define FTE_ENT_W 6
`define FTE_ENT_LAST 5
`define FTE_ENT_ERR 4

// ----------------------------------------------------------------
// Serialiser, scrambler and MLT-3
// ----------------------------------------------------------------
`define FTE_BIT_LAST 3'h4
`define FTE_SCR_TAP_A 10
`define FTE_SCR_TAP_B 8
`define FTE_SEED_WAIT 2'h3
`define FTE_MLT_POS 2'h1
`define FTE_MLT_NEG 2'h3

`endif

// File: rtl/fte_fifo.v
/*
  Synchronous FIFO with valid/ready on both sides, flip-flop storage.
  Assumes one clock and an asynchronous active-high reset.
*/
`timescale 1ns/1ps
module fte_fifo #(
  parameter WIDTH = 6,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  // Clock and reset
  input wire sys_clk_i,
  input wire rst_i,
  // Filling side
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  // Draining side
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  reg full;
  reg not_full;
  reg empty;
  reg [AW:0] next_count;
  wire push;
  wire pop;

  assign push = in_valid_i & ~full;
  assign pop = out_ready_i & ~empty;
  assign in_ready_o = not_full; // Ready comes straight from a flop
  assign out_valid_o = ~empty;
  assign out_data_o = mem[rd_ptr];

  // Occupancy after this cycle
  always @* begin
    next_count = count;
    if (push & ~pop)
      next_count = count + 1'b1;
    else if (pop & ~push)
      next_count = count - 1'b1;
  end

  // Pointers and registered full/empty flags
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
      full <= 1'b0;
      not_full <= 1'b1;
      empty <= 1'b1;
    end else begin
      if (push)
        wr_ptr <= (wr_ptr == DEPTH - 1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == DEPTH - 1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      count <= next_count;
      full <= (next_count == DEPTH);
      not_full <= (next_count != DEPTH);
      empty <= (next_count == {(AW+1){1'b0}});
    end
  end

  // Storage, written per entry
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi = gi + 1) begin : g_ent
      always @(posedge sys_clk_i) begin
        if (push && wr_ptr == gi)
          mem[gi] <= in_data_i;
      end
    end
  endgenerate
endmodule // fte_fifo

// File: rtl/fte_tx_coder.v
/*
  100 Mb/s transmit coding path: MII nibble intake with error forwarding,
  4B/5B encoding with delimiters and IDLE fill, serialiser, scrambler,
  NRZI and MLT-3 coding, plus the 5B/4B receive interpretation.
  Assumes the MAC and the code-group receive source run on sys_clk_i;
  the PHY address strap and the forwarding-off control are pins.
*/
`timescale 1ns/1ps
`include "fte_consts.vh"
module fte_tx_coder (
  // Clock and reset
  input wire sys_clk_i,
  input wire rst_i,
  // Straps and control pins
  input wire [4:0] phy_addr_i,
  input wire err_fwd_off_i,
  // MII transmit from the MAC
  input wire [3:0] mii_txd_i,
  input wire mii_tx_en_i,
  input wire mii_tx_er_i,
  output wire tx_ready_o,
  // Line side
  output reg [4:0] tx_code_o,
  output reg tx_scr_bit_o,
  output reg tx_nrzi_o,
  output reg tx_mlt3_pos_o,
  output reg tx_mlt3_neg_o,
  // Code-groups to interpret
  input wire [4:0] rx_code_i,
  input wire rx_code_valid_i,
  // MII-style receive results
  output reg [3:0] rx_nibble_o,
  output reg rx_nibble_valid_o,
  output reg rx_dv_o,
  output reg rx_er_o,
  output reg rx_crs_o
);
  // One-hot encoder states: what the next code-group load will send
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_SSD2 = 5'h02;
  localparam [4:0] ST_DATA = 5'h04;
  localparam [4:0] ST_ESD1 = 5'h08;
  localparam [4:0] ST_ESD2 = 5'h10;

  // ----------------------------------------------------------------
  // Code tables
  // ----------------------------------------------------------------
  // Data code-groups for nibbles F down to 0, five bits each
  localparam [79:0] ENC_TAB = {5'h1d, 5'h1c, 5'h1b, 5'h1a, 5'h17, 5'h16, 5'h13, 5'h12,
    5'h0f, 5'h0e, 5'h0b, 5'h0a, 5'h15, 5'h14, 5'h09, 5'h1e};
  function [4:0] fte_enc;
    input [3:0] nib;
    begin
      fte_enc = ENC_TAB[nib*5 +: 5];
    end
  endfunction
  // Reverse lookup: bit 4 flags a data code-group
  function [4:0] fte_dec;
    input [4:0] cg;
    integer k;
    reg [4:0] r;
    begin
      r = 5'h00;
      for (k = 0; k < 16; k = k + 1) begin
        if (fte_enc(k[3:0]) == cg)
          r = {1'b1, k[3:0]};
      end
      fte_dec = r;
    end
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  reg [4:0] addr_s1;
  reg [4:0] addr_s2;
  reg fwd_off_s1;
  reg fwd_off_s2;
  // Two flops per pin; reset leaves forwarding enabled
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      {addr_s1, addr_s2} <= 10'h000;
      {fwd_off_s1, fwd_off_s2} <= 2'h0;
    end else begin
      addr_s1 <= phy_addr_i;
      addr_s2 <= addr_s1;
      fwd_off_s1 <= err_fwd_off_i;
      fwd_off_s2 <= fwd_off_s1;
    end
  end

  // ----------------------------------------------------------------
  // MII intake and error forwarding
  // ----------------------------------------------------------------
  reg [3:0] hold_nib;
  reg hold_er;
  reg hold_vld;
  reg odd_cnt;
  reg ext_pend;
  reg push_vld;
  reg [5:0] push_data;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [5:0] fifo_out_data;
  wire fifo_pop;
  // One nibble held back so the last one can be marked on enable fall
  always @* begin
    push_vld = 1'b0;
    push_data = {1'b0, hold_er, hold_nib};
    if (ext_pend) begin
      push_vld = 1'b1;
      push_data = {1'b1, 1'b1, 4'h0}; // Extension cycle acts as an error
    end else if (mii_tx_en_i) begin
      push_vld = hold_vld;
    end else if (hold_vld) begin
      push_vld = 1'b1;
      // Last nibble, unless an error nibble still follows
      push_data[`FTE_ENT_LAST] = ~(odd_cnt & ~fwd_off_s2);
    end
  end
  // Hold stage, nibble parity and pending extension
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      hold_nib <= 4'h0;
      {hold_er, hold_vld, odd_cnt, ext_pend} <= 4'h0;
    end else if (fifo_in_ready) begin
      if (ext_pend) begin
        ext_pend <= 1'b0;
      end else if (mii_tx_en_i) begin
        hold_nib <= mii_txd_i;
        hold_er <= mii_tx_er_i;
        hold_vld <= 1'b1;
        odd_cnt <= ~odd_cnt;
      end else if (hold_vld) begin
        hold_vld <= 1'b0;
        odd_cnt <= 1'b0;
        ext_pend <= odd_cnt & ~fwd_off_s2;
      end
    end
  end

  // Eight-entry buffer between MII rate and code-group rate
  fte_fifo #(
    .WIDTH(`FTE_ENT_W),
    .DEPTH(`FTE_FIFO_DEPTH),
    .AW(`FTE_FIFO_AW)
  ) u_fifo (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .in_valid_i(push_vld),
    .in_ready_o(fifo_in_ready),
    .in_data_i(push_data),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_out_data)
  );
  assign tx_ready_o = fifo_in_ready;

  // ----------------------------------------------------------------
  // Code-group encoder and serialiser
  // ----------------------------------------------------------------
  reg [4:0] state;
  reg [4:0] next_state;
  reg [4:0] next_code;
  reg pop_req;
  reg [2:0] bit_cnt;
  reg [4:0] shreg;
  wire load;

  assign load = (bit_cnt == `FTE_BIT_LAST);
  assign fifo_pop = load & pop_req;

  // Choice of the next code-group
  always @* begin
    next_state = state;
    next_code = `FTE_CG_IDLE;
    pop_req = 1'b0;
    case (state)
      ST_IDLE: begin
        if (fifo_out_valid) begin
          next_code = `FTE_CG_J; // First preamble nibble replaced
          pop_req = 1'b1;
          next_state = ST_SSD2;
        end
      end
      ST_SSD2: begin
        next_code = `FTE_CG_K; // Second preamble nibble replaced
        pop_req = fifo_out_valid;
        next_state = ST_DATA;
      end
      ST_DATA: begin
        next_code = `FTE_CG_H; // Underrun or error entry is sent as H
        if (fifo_out_valid) begin
          pop_req = 1'b1;
          if (!fifo_out_data[`FTE_ENT_ERR])
            next_code = fte_enc(fifo_out_data[3:0]);
          if (fifo_out_data[`FTE_ENT_LAST])
            next_state = ST_ESD1;
        end
      end
      ST_ESD1: begin
        next_code = `FTE_CG_T;
        next_state = ST_ESD2;
      end
      ST_ESD2: begin
        next_code = `FTE_CG_R;
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Shift out MSB first, reload every fifth clock
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      bit_cnt <= `FTE_BIT_LAST;
      shreg <= `FTE_CG_IDLE;
      tx_code_o <= `FTE_CG_IDLE;
    end else if (load) begin
      state <= next_state;
      bit_cnt <= 3'h0;
      shreg <= next_code;
      tx_code_o <= next_code;
    end else begin
      bit_cnt <= bit_cnt + 3'h1;
      shreg <= {shreg[3:0], 1'b0};
    end
  end

  // ----------------------------------------------------------------
  // Scrambler, NRZI and MLT-3
  // ----------------------------------------------------------------
  reg [10:0] lfsr;
  reg [1:0] seed_wait;
  reg [1:0] mlt_phase;
  reg [1:0] next_phase;
  wire scr_bit;

  assign scr_bit = shreg[4] ^ lfsr[`FTE_SCR_TAP_A];

  // MLT-3 phase steps on each one bit, holds on zero
  always @* begin
    next_phase = mlt_phase;
    if (scr_bit)
      next_phase = mlt_phase + 2'h1;
  end

  // Seed reloaded from the synchronised address until it has settled
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      lfsr <= 11'h001;
      seed_wait <= 2'h0;
    end else if (seed_wait != `FTE_SEED_WAIT) begin
      seed_wait <= seed_wait + 2'h1;
      lfsr <= {addr_s2, ~addr_s2, 1'b1};
    end else begin
      lfsr <= {lfsr[9:0], lfsr[`FTE_SCR_TAP_A] ^ lfsr[`FTE_SCR_TAP_B]};
    end
  end

  // Line coding registers
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      {tx_scr_bit_o, tx_nrzi_o, tx_mlt3_pos_o, tx_mlt3_neg_o} <= 4'h0;
      mlt_phase <= 2'h0;
    end else begin
      tx_scr_bit_o <= scr_bit;
      tx_nrzi_o <= tx_nrzi_o ^ scr_bit;
      mlt_phase <= next_phase;
      tx_mlt3_pos_o <= (next_phase == `FTE_MLT_POS);
      tx_mlt3_neg_o <= (next_phase == `FTE_MLT_NEG);
    end
  end

  // ----------------------------------------------------------------
  // Receive code-group interpretation
  // ----------------------------------------------------------------
  reg [4:0] prev_code;
  reg in_frame;
  reg t_pend;
  wire [4:0] dec;

  assign dec = fte_dec(rx_code_i);

  // Delimiter checks and data decode, one result per code-group
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      prev_code <= `FTE_CG_IDLE;
      {in_frame, t_pend} <= 2'h0;
      rx_nibble_o <= 4'h0;
      {rx_nibble_valid_o, rx_dv_o, rx_er_o, rx_crs_o} <= 4'h0;
    end else begin
      rx_nibble_valid_o <= 1'b0;
      if (rx_code_valid_i) begin
        prev_code <= rx_code_i;
        rx_er_o <= 1'b0;
        if (t_pend) begin
          t_pend <= 1'b0;
          in_frame <= 1'b0;
          rx_dv_o <= 1'b0;
          rx_crs_o <= 1'b0;
          rx_er_o <= (rx_code_i != `FTE_CG_R);
        end else if (rx_code_i == `FTE_CG_J) begin
          if (prev_code == `FTE_CG_IDLE && !in_frame) begin
            in_frame <= 1'b1;
            rx_crs_o <= 1'b1;
            rx_dv_o <= 1'b1;
            rx_nibble_o <= `FTE_NIB_PRE;
            rx_nibble_valid_o <= 1'b1;
          end else begin
            rx_er_o <= 1'b1;
          end
        end else if (rx_code_i == `FTE_CG_K) begin
          if (prev_code == `FTE_CG_J && in_frame) begin
            rx_nibble_o <= `FTE_NIB_PRE;
            rx_nibble_valid_o <= 1'b1;
          end else begin
            rx_er_o <= 1'b1;
          end
        end else if (rx_code_i == `FTE_CG_T) begin
          t_pend <= 1'b1; // Judged when the next code-group arrives
        end else if (rx_code_i == `FTE_CG_R) begin
          rx_er_o <= 1'b1;
        end else if (rx_code_i == `FTE_CG_IDLE) begin
          if (in_frame) begin
            rx_er_o <= 1'b1;
            in_frame <= 1'b0;
            rx_dv_o <= 1'b0;
            rx_crs_o <= 1'b0;
          end
        end else if (in_frame) begin
          rx_nibble_o <= dec[3:0];
          rx_nibble_valid_o <= 1'b1;
          rx_er_o <= ~dec[4];
        end
      end
    end
  end
endmodule // fte_tx_coder

// File: dv/fte_tx_coder_chk.sv
/*
  Checker for the transmit coder: code-group order, line coding and
  receive interpretation. Assumes it is bound to fte_tx_coder.
*/
`timescale 1ns/1ps
`include "fte_consts.vh"
module fte_tx_coder_chk (
  // Clock and reset
  input logic sys_clk_i,
  input logic rst_i,
  // Line side
  input logic [4:0] tx_code_o,
  input logic tx_scr_bit_o,
  input logic tx_nrzi_o,
  input logic tx_mlt3_pos_o,
  input logic tx_mlt3_neg_o,
  // Receive side
  input logic [4:0] rx_code_i,
  input logic rx_code_valid_i,
  input logic [3:0] rx_nibble_o,
  input logic rx_dv_o,
  input logic rx_er_o,
  input logic rx_crs_o
);
  logic [4:0] prev_cg;
  logic last_pos;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // Last code-group taken on the receive strobe
  always @(posedge sys_clk_i or posedge rst_i)
    if (rst_i) prev_cg <= `FTE_CG_IDLE;
    else if (rx_code_valid_i) prev_cg <= rx_code_i;
  // Polarity of the last non-zero line level
  always @(posedge sys_clk_i or posedge rst_i)
    if (rst_i) last_pos <= 1'b0;
    else if (tx_mlt3_pos_o || tx_mlt3_neg_o) last_pos <= tx_mlt3_pos_o;
  // ----------------------------------------------------------------
  // Transmit line
  // ----------------------------------------------------------------
  code_hold_a: assert property (
    $changed(tx_code_o) |=> $stable(tx_code_o) [*4]) else $error("code-group too short");
  start_pair_a: assert property (
    $changed(tx_code_o) && tx_code_o == `FTE_CG_J |-> ##5 tx_code_o == `FTE_CG_K)
    else $error("J not followed by K");
  end_pair_a: assert property (
    $changed(tx_code_o) && tx_code_o == `FTE_CG_T |-> ##5 tx_code_o == `FTE_CG_R)
    else $error("T not followed by R");
  idle_fill_a: assert property (
    $changed(tx_code_o) && tx_code_o == `FTE_CG_R |-> ##5
    (tx_code_o == `FTE_CG_IDLE || tx_code_o == `FTE_CG_J)) else $error("no IDLE after R");
  nrzi_step_a: assert property (
    tx_nrzi_o == ($past(tx_nrzi_o) ^ tx_scr_bit_o)) else $error("NRZI level wrong");
  mlt_step_a: assert property (
    tx_scr_bit_o == (!$stable(tx_mlt3_pos_o) || !$stable(tx_mlt3_neg_o)))
    else $error("MLT-3 step wrong");
  mlt_order_a: assert property (
    $rose(tx_mlt3_pos_o || tx_mlt3_neg_o) |-> tx_mlt3_pos_o == !last_pos)
    else $error("MLT-3 level order wrong");
  // ----------------------------------------------------------------
  // Receive interpretation
  // ----------------------------------------------------------------
  rx_start_a: assert property (
    rx_code_valid_i && rx_code_i == `FTE_CG_J && prev_cg == `FTE_CG_IDLE |=>
    rx_dv_o && rx_crs_o && rx_nibble_o == 4'h5 && !rx_er_o) else $error("bad frame start");
  rx_stray_j_a: assert property (
    rx_code_valid_i && rx_code_i == `FTE_CG_J && prev_cg != `FTE_CG_IDLE |=> rx_er_o)
    else $error("stray J accepted");
  rx_stray_k_a: assert property (
    rx_code_valid_i && rx_code_i == `FTE_CG_K && prev_cg != `FTE_CG_J |=> rx_er_o)
    else $error("stray K accepted");
  rx_end_a: assert property (
    rx_code_valid_i && rx_code_i == `FTE_CG_R && prev_cg == `FTE_CG_T |=>
    !rx_dv_o && !rx_crs_o && !rx_er_o) else $error("end pair mishandled");
  rx_lone_r_a: assert property (
    rx_code_valid_i && rx_code_i == `FTE_CG_R && prev_cg != `FTE_CG_T |=> rx_er_o)
    else $error("stray R accepted");
  rx_invalid_a: assert property (
    rx_code_valid_i && rx_dv_o && rx_code_i inside {5'h00, 5'h01, 5'h02, 5'h03, 5'h05, 5'h06}
    |=> rx_er_o) else $error("invalid code accepted");
  rx_er_hold_a: assert property (
    !rx_code_valid_i |=> $stable(rx_er_o)) else $error("receive error moved");
endmodule // fte_tx_coder_chk

// File: dv/fte_mac_model.sv
/*
  MAC model on the MII transmit side, one nibble per accepted clock.
  Assumes tx_ready_i is registered on sys_clk_i.
*/
`timescale 1ns/1ps
module fte_mac_model (
  // Clock
  input logic sys_clk_i,
  // MII transmit towards the coder
  input logic tx_ready_i,
  output logic [3:0] mii_txd_o,
  output logic mii_tx_en_o,
  output logic mii_tx_er_o
);
  // Idle line
  initial begin
    mii_txd_o = 4'h0;
    mii_tx_en_o = 1'b0;
    mii_tx_er_o = 1'b0;
  end
  // Frame of n nibbles base+i, error flag on nibble er_at; held while refused
  task automatic send(input int n, input logic [3:0] base, input int er_at);
    int i;
    logic rdy;
    i = 0;
    while (i < n) begin
      mii_tx_en_o = 1'b1;
      mii_txd_o = base + i[3:0];
      mii_tx_er_o = (i == er_at);
      rdy = tx_ready_i;
      @(negedge sys_clk_i);
      if (rdy === 1'b1) i++;
    end
    mii_tx_en_o = 1'b0;
    mii_tx_er_o = 1'b0;
    mii_txd_o = ~mii_txd_o; // Released data does not keep its value
  endtask
endmodule // fte_mac_model

// File: dv/tb.sv
/*
  Self-checking bench for the transmit coder with a MAC model.
  Assumes the design and checker files are compiled before it.
*/
`timescale 1ns/1ps
`include "fte_consts.vh"
module tb;
  typedef struct {int n; logic [3:0] base; int er_at; logic off;} fte_row_t;
  localparam logic [4:0] ENC [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e,
    5'h0f, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [4:0] phy_addr_i = 5'h03;
  logic err_fwd_off_i = 1'b0;
  logic [4:0] rx_code_i = 5'h1f;
  logic rx_code_valid_i = 1'b0;
  logic [3:0] mii_txd_i, rx_nibble_o;
  logic mii_tx_en_i, mii_tx_er_i, tx_ready_o, tx_scr_bit_o, tx_nrzi_o;
  logic tx_mlt3_pos_o, tx_mlt3_neg_o, rx_nibble_valid_o, rx_dv_o, rx_er_o, rx_crs_o;
  logic [4:0] tx_code_o;
  logic [4:0] q [$];
  logic [4:0] exp_q [$];
  logic cap = 1'b0;
  logic [39:0] s1, s2;
  int err_total = 0;
  int comparisons = 0;
  int pc, cyc = 0;
  fte_row_t rows [6] = '{'{4, 4'h0, -1, 1'b0}, '{3, 4'h5, -1, 1'b0}, '{5, 4'h0, -1, 1'b1},
    '{6, 4'h1, -1, 1'b1}, '{18, 4'h0, -1, 1'b0}, '{21, 4'h7, 4, 1'b0}};
  always #12.5 sys_clk_i = ~sys_clk_i;
  fte_tx_coder i_fte_tx_coder (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .phy_addr_i(phy_addr_i), .err_fwd_off_i(err_fwd_off_i), .mii_txd_i(mii_txd_i),
    .mii_tx_en_i(mii_tx_en_i), .mii_tx_er_i(mii_tx_er_i), .tx_ready_o(tx_ready_o),
    .tx_code_o(tx_code_o), .tx_scr_bit_o(tx_scr_bit_o), .tx_nrzi_o(tx_nrzi_o),
    .tx_mlt3_pos_o(tx_mlt3_pos_o), .tx_mlt3_neg_o(tx_mlt3_neg_o), .rx_code_i(rx_code_i),
    .rx_code_valid_i(rx_code_valid_i), .rx_nibble_o(rx_nibble_o),
    .rx_nibble_valid_o(rx_nibble_valid_o), .rx_dv_o(rx_dv_o), .rx_er_o(rx_er_o),
    .rx_crs_o(rx_crs_o));
  fte_mac_model i_fte_mac_model (.sys_clk_i(sys_clk_i), .tx_ready_i(tx_ready_o),
    .mii_txd_o(mii_txd_i), .mii_tx_en_o(mii_tx_en_i), .mii_tx_er_o(mii_tx_er_i));
  // Clocks since reset release; code-groups load every fifth
  always @(posedge sys_clk_i or posedge rst_i)
    if (rst_i) pc <= 0;
    else pc <= pc + 1;
  // Capture one code-group per load, from J to the IDLE after the frame
  always @(negedge sys_clk_i)
    if (!rst_i && pc % 5 == 3) begin
      if (tx_code_o === `FTE_CG_J) cap = 1'b1;
      if (cap) q.push_back(tx_code_o);
      if (tx_code_o === `FTE_CG_IDLE) cap = 1'b0;
    end
  // Hang guard
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      $display("wrong value at %0t: run timed out", $time);
      test_done();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic do_reset(input logic [4:0] addr);
    @(negedge sys_clk_i);
    rst_i = 1'b1;
    phy_addr_i = addr;
    repeat (2) @(negedge sys_clk_i);
    rst_i = 1'b0;
  endtask
  // One frame through the MAC model, line code-groups compared in order
  task automatic run_frame(input fte_row_t r);
    int k;
    q.delete();
    exp_q = '{`FTE_CG_J, `FTE_CG_K};
    err_fwd_off_i = r.off;
    repeat (4) @(negedge sys_clk_i);
    for (k = 2; k < r.n; k++)
      exp_q.push_back(k == r.er_at ? `FTE_CG_H : ENC[r.base + k[3:0]]);
    if (r.n % 2 == 1 && !r.off) exp_q.push_back(`FTE_CG_H);
    exp_q.push_back(`FTE_CG_T);
    exp_q.push_back(`FTE_CG_R);
    exp_q.push_back(`FTE_CG_IDLE);
    i_fte_mac_model.send(r.n, r.base, r.er_at);
    for (k = 0; k < 800 && !(q.size() > 0 && q[$] === `FTE_CG_IDLE); k++)
      @(negedge sys_clk_i);
    check(8'(q.size()), 8'(exp_q.size()), "frame length");
    for (k = 0; k < exp_q.size() && k < q.size(); k++)
      check(8'(q[k]), 8'(exp_q[k]), "code-group");
  endtask
  // One received code-group, results looked at one clock later
  task automatic rx(input logic [4:0] cg, input logic chk, input logic er, input logic dv);
    rx_code_i = cg;
    rx_code_valid_i = 1'b1;
    @(negedge sys_clk_i);
    if (chk) begin
      check(8'(rx_er_o), 8'(er), "receive error");
      check(8'({rx_dv_o, rx_crs_o}), 8'({dv, dv}), "frame valid");
    end
  endtask
  // Main sequence
  initial begin
    int r;
    do_reset(5'h03);
    check(8'(tx_code_o), 8'(`FTE_CG_IDLE), "reset code");
    check(8'({tx_ready_o, rx_dv_o, rx_er_o, rx_crs_o}), 8'h08, "reset flags");
    repeat (12) @(negedge sys_clk_i);
    check(8'(tx_code_o), 8'(`FTE_CG_IDLE), "idle line");
    for (r = 0; r < 6; r++) begin
      run_frame(rows[r]);
      $display("test frame %0d done", r);
    end
    rx(`FTE_CG_IDLE, 1, 0, 0);
    rx(`FTE_CG_J, 1, 0, 1);
    rx(`FTE_CG_K, 1, 0, 1);
    rx(5'h0e, 1, 0, 1);
    check(8'({rx_nibble_valid_o, rx_nibble_o}), 8'h16, "nibble");
    rx(`FTE_CG_T, 0, 0, 0);
    rx(`FTE_CG_R, 1, 0, 0);
    rx(`FTE_CG_IDLE, 1, 0, 0);
    rx(`FTE_CG_J, 1, 0, 1);
    rx(`FTE_CG_K, 1, 0, 1);
    rx(5'h00, 1, 1, 1);
    rx(5'h06, 1, 1, 1);
    rx(`FTE_CG_H, 1, 1, 1);
    rx(`FTE_CG_J, 1, 1, 1);
    rx(`FTE_CG_T, 0, 0, 0);
    rx(5'h0b, 1, 1, 0);
    rx(`FTE_CG_R, 1, 1, 0);
    rx(5'h1e, 1, 0, 0);
    rx(`FTE_CG_J, 0, 0, 0);
    check(8'(rx_er_o), 8'h01, "start not after idle");
    rx(`FTE_CG_IDLE, 0, 0, 0);
    rx(`FTE_CG_IDLE, 0, 0, 0);
    rx(`FTE_CG_K, 0, 0, 0);
    check(8'(rx_er_o), 8'h01, "second start alone");
    rx_code_valid_i = 1'b0;
    $display("test receive done");
    scr_take(5'h03, s1);
    scr_take(5'h1c, s2);
    check(8'(s1 !== s2), 8'h01, "scrambler seed");
    run_frame(rows[1]);
    $display("test scrambler and reset done");
    test_done();
  end
  task automatic scr_take(input logic [4:0] addr, output logic [39:0] v);
    int k;
    do_reset(addr);
    for (k = 0; k < 40; k++) begin
      @(negedge sys_clk_i);
      v[k] = tx_scr_bit_o;
    end
  endtask
endmodule // tb
bind fte_tx_coder fte_tx_coder_chk i_fte_tx_coder_chk (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
  .tx_code_o(tx_code_o), .tx_scr_bit_o(tx_scr_bit_o), .tx_nrzi_o(tx_nrzi_o),
  .tx_mlt3_pos_o(tx_mlt3_pos_o), .tx_mlt3_neg_o(tx_mlt3_neg_o), .rx_code_i(rx_code_i),
  .rx_code_valid_i(rx_code_valid_i), .rx_nibble_o(rx_nibble_o), .rx_dv_o(rx_dv_o),
  .rx_er_o(rx_er_o), .rx_crs_o(rx_crs_o));
